// ==== bench/phy_line_model.sv ====
// Behavioural model of the PHY side: raw line state and suspend level.
// Assumes the bench commands each value just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module phy_line_model (
    input  wire logic       clock,
    input  wire logic [1:0] lineCmd,
    input  wire logic       suspCmd,
    output logic [1:0]      lineStateRaw,
    output logic            suspended
);
    // ========================================
    // Line and suspend level
    // Registered so every change lands one edge after the command,
    // and the bench polls the filtered copy, never this one
    always_ff @(posedge clock) begin
        lineStateRaw <= lineCmd;
        suspended    <= suspCmd;
    end
endmodule
`default_nettype wire

// ==== bench/usb_phy_ctrl_tb.sv ====
// Self-checking bench for the USB PHY control register block.
// Assumes the design's AXI4-Lite slave and the PHY line model.
`timescale 1ns/1ns
`default_nettype none
module usb_phy_ctrl_tb;
    logic [31:0] awAddr = '0, wData = '0, arAddr = '0, rData;
    logic [3:0]  wStrb = '0;
    logic        clock = 0, sysRst = 1, suspCmd = 0, suspended;
    logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0;
    logic        rReady = 0, awReady, wReady, bValid, arReady, rValid;
    logic        resumeReq;
    logic [1:0]  bResp, rResp, filt, lineRaw, resp, lineCmd = 2'h1;
    logic [31:0] data;
    usb_phy_ctrl_pkg::phy_out_s phyOut;
    int          miscompares = 0, nTests = 0, pulses = 0;
    // ========================================
    // Clock, design and partner
    initial begin
        forever #5 clock = ~clock;
    end
    usb_phy_ctrl u_usb_phy_ctrl (.clock(clock), .sys_rst(sysRst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .lineStateRaw(lineRaw),
        .suspended(suspended), .filtLineState(filt),
        .resumeReq(resumeReq), .phyOut(phyOut));
    phy_line_model u_phy_line_model (.clock(clock), .lineCmd(lineCmd),
        .suspCmd(suspCmd), .lineStateRaw(lineRaw), .suspended(suspended));
    always @(posedge clock) begin
        if (resumeReq === 1'b1) pulses++;
    end
    // ========================================
    // Bus cycles and compare
    task chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        bit aDone, wDone;
        int i;
        awAddr <= a; wData <= d; wStrb <= s; awValid <= 1; wValid <= 1;
        aDone = 0; wDone = 0;
        for (i = 0; i < 50 && !(aDone && wDone); i++) begin
            @(posedge clock);
            if (!aDone && awReady === 1'b1) begin aDone = 1; awValid <= 0; end
            if (!wDone && wReady === 1'b1) begin wDone = 1; wValid <= 0; end
        end
        bReady <= 1; i = 0;
        do @(posedge clock); while (bValid !== 1'b1 && ++i < 50);
        if (bValid !== 1'b1) miscompares++;
        resp = bResp; bReady <= 0;
    endtask
    task rd(input logic [31:0] a);
        int i;
        arAddr <= a; arValid <= 1; i = 0;
        do @(posedge clock); while (arReady !== 1'b1 && ++i < 50);
        arValid <= 0; rReady <= 1; i = 0;
        do @(posedge clock); while (rValid !== 1'b1 && ++i < 50);
        if (rValid !== 1'b1) miscompares++;
        data = rData; resp = rResp; rReady <= 0;
    endtask
    task wait_filt(input logic [1:0] exp);
        int i;
        for (i = 0; i < 20 && filt !== exp; i++) @(posedge clock);
        chk(filt, exp);
    endtask
    // ========================================
    // Scenarios
    task t_reset;
        rd(32'h40); chk(data, 32'h0);
        chk(phyOut, 6'h00);
    endtask
    task t_fields;
        wr(32'h40, 32'hffffffff, 4'hf); chk(resp, 2'h0);
        rd(32'h40); chk(data, 32'h00040ff0);
        chk(phyOut, 6'h3f);
        wr(32'h40, 32'h00000050, 4'hf); chk(phyOut, 6'h0a);
        wr(32'h40, 32'hffffffff, 4'h4); chk(phyOut, 6'h3a);
    endtask
    task t_unmapped;
        wr(32'h44, 32'hffffffff, 4'hf); chk(resp, 2'h2);
        rd(32'h44); chk(data, 32'h0);
        chk(resp, 2'h2);
        rd(32'h40); chk(data, 32'h00040050);
    endtask
    task t_filter;
        wr(32'h40, 32'h00000280, 4'hf); wait_filt(2'h1);
        suspCmd <= 1; lineCmd <= 2'h2; @(posedge clock);
        lineCmd <= 2'h1; repeat (16) @(posedge clock);
        chk(filt, 2'h1);
        lineCmd <= 2'h2; repeat (4) @(posedge clock);
        chk(filt, 2'h1);
        wait_filt(2'h2); rd(32'h40); chk(data, 32'h00001280);
        chk(pulses, 1);
        lineCmd <= 2'h0; wait_filt(2'h0);
        rd(32'h40); chk(data, 32'h00003280);
        wr(32'h40, 32'h00000280, 4'hf);
        rd(32'h40); chk(data, 32'h00000280);
        wr(32'h40, 32'h00000200, 4'hf); lineCmd <= 2'h2; wait_filt(2'h2);
        rd(32'h40); chk(data, 32'h00000200);
        chk(pulses, 2);
    endtask
    // ========================================
    // Verdict and watchdog
    task report_and_stop;
        $display("tests %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge clock);
        sysRst <= 0;
        @(posedge clock);
        t_reset(); t_fields(); t_unmapped(); t_filter();
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== hw/usb_phy_ctrl.sv ====
// USB PHY control register with line-state filter and auto-resume flags.
// Assumes an AXI4-Lite master on clock and raw PHY line state on pins.
// Operation
// - Bit 18 set turns both pulldowns off
// - SE0 auto-resume sets sticky bit 13
// - K auto-resume sets sticky bit 12
// - Line change passes after 2^n + 1 stable clocks
// - Bit 7 selects hardware resume, else polling
// - Bits 6:4 drive PHY config pins
`timescale 1ns/1ns
`default_nettype none
module usb_phy_ctrl (
    input  wire logic                        clock,
    input  wire logic                        sys_rst,
    input  wire logic [31:0]                 s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [31:0]                 s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [1:0]                  lineStateRaw,
    input  wire logic                        suspended,
    output logic [1:0]                       filtLineState,
    output logic                             resumeReq,
    output usb_phy_ctrl_pkg::phy_out_s       phyOut
);

    usb_phy_ctrl_pkg::state_s st_r;
    usb_phy_ctrl_pkg::state_s st_nxt;

    logic        doWrite;
    logic        hit;
    logic        clrSe0;
    logic        clrK;
    logic [15:0] lastCnt;
    logic [31:0] regView;

    // ========================================
    // Register view, reserved bits forced low
    always_comb begin
        regView = 32'h0;
        regView[usb_phy_ctrl_pkg::PULLDOWN_OFF_BIT] = st_r.pdOff;
        regView[usb_phy_ctrl_pkg::SE0_RESUME_BIT]   = st_r.se0Flag;
        regView[usb_phy_ctrl_pkg::K_RESUME_BIT]     = st_r.kFlag;
        regView[usb_phy_ctrl_pkg::FILTER_LSB +: 4]  = st_r.filterLog;
        regView[usb_phy_ctrl_pkg::HW_RESUME_BIT]    = st_r.hwResume;
        regView[usb_phy_ctrl_pkg::PHY_CONFIG_LSB +: 3] = st_r.phyCfg;
    end

    assign doWrite = st_r.awHeld && st_r.wHeld && !st_r.bValid;
    assign hit     = st_r.awAddr == usb_phy_ctrl_pkg::PHY_CONTROL_ADDR;
    // Flags clear only on a written 0; a written 1 leaves them alone
    assign clrSe0  = doWrite && hit && st_r.wStrb[1]
                     && !st_r.wData[usb_phy_ctrl_pkg::SE0_RESUME_BIT];
    assign clrK    = doWrite && hit && st_r.wStrb[1]
                     && !st_r.wData[usb_phy_ctrl_pkg::K_RESUME_BIT];
    assign lastCnt = 16'((17'h1 << st_r.filterLog) - 17'h1);

    // ========================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.resumeReq = 1'b0;

        // Write channel: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.awHeld = 1'b1;
            st_nxt.awAddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.wHeld = 1'b1;
            st_nxt.wData = s_axi_wdata;
            st_nxt.wStrb = s_axi_wstrb;
        end
        if (doWrite) begin
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld  = 1'b0;
            st_nxt.bValid = 1'b1;
            st_nxt.bResp  = hit ? usb_phy_ctrl_pkg::RESP_OKAY
                                : usb_phy_ctrl_pkg::RESP_SLV;
            if (hit && st_r.wStrb[0]) begin
                st_nxt.hwResume =
                    st_r.wData[usb_phy_ctrl_pkg::HW_RESUME_BIT];
                st_nxt.phyCfg   =
                    st_r.wData[usb_phy_ctrl_pkg::PHY_CONFIG_LSB +: 3];
            end
            if (hit && st_r.wStrb[1]) begin
                st_nxt.filterLog =
                    st_r.wData[usb_phy_ctrl_pkg::FILTER_LSB +: 4];
            end
            if (hit && st_r.wStrb[2]) begin
                st_nxt.pdOff =
                    st_r.wData[usb_phy_ctrl_pkg::PULLDOWN_OFF_BIT];
            end
        end
        if (st_r.bValid && s_axi_bready) begin
            st_nxt.bValid = 1'b0;
        end

        // Read channel: data one cycle after the address
        if (s_axi_arvalid && s_axi_arready) begin
            st_nxt.rValid = 1'b1;
            if (s_axi_araddr[7:0] == usb_phy_ctrl_pkg::PHY_CONTROL_ADDR) begin
                st_nxt.rData = regView;
                st_nxt.rResp = usb_phy_ctrl_pkg::RESP_OKAY;
            end else begin
                st_nxt.rData = 32'h0;
                st_nxt.rResp = usb_phy_ctrl_pkg::RESP_SLV;
            end
        end else if (st_r.rValid && s_axi_rready) begin
            st_nxt.rValid = 1'b0;
        end

        // Line state: two-stage synchroniser, then stability filter
        st_nxt.syncA = lineStateRaw;
        st_nxt.syncB = st_r.syncA;
        if (st_r.syncB != st_r.cand) begin
            st_nxt.cand = st_r.syncB;
            st_nxt.cnt  = 16'h0;
        end else if (st_r.cand != st_r.filt) begin
            if (st_r.cnt == lastCnt) begin
                st_nxt.filt = st_r.cand;
                st_nxt.cnt  = 16'h0;
            end else begin
                st_nxt.cnt = st_r.cnt + 16'h1;
            end
        end

        // Sticky flags: a set in the clearing cycle wins
        st_nxt.se0Flag = st_r.se0Flag && !clrSe0;
        st_nxt.kFlag   = st_r.kFlag && !clrK;
        if (st_r.hwResume && suspended && st_nxt.filt != st_r.filt) begin
            if (st_nxt.filt == usb_phy_ctrl_pkg::LINE_SE0) begin
                st_nxt.resumeReq = 1'b1;
                st_nxt.se0Flag   = 1'b1;
            end else if (st_nxt.filt == usb_phy_ctrl_pkg::LINE_K) begin
                st_nxt.resumeReq = 1'b1;
                st_nxt.kFlag     = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================
    // Outputs
    // Back-pressure while a response is pending keeps one write in flight
    assign s_axi_awready = !st_r.awHeld && !st_r.bValid;
    assign s_axi_wready  = !st_r.wHeld && !st_r.bValid;
    assign s_axi_bvalid  = st_r.bValid;
    assign s_axi_bresp   = st_r.bResp;
    assign s_axi_arready = !st_r.rValid;
    assign s_axi_rvalid  = st_r.rValid;
    assign s_axi_rdata   = st_r.rData;
    assign s_axi_rresp   = st_r.rResp;
    assign filtLineState = st_r.filt;
    assign resumeReq     = st_r.resumeReq;
    assign phyOut.pulldownDisable = {2{st_r.pdOff}};
    assign phyOut.phyConfigInputs = st_r.phyCfg;
    assign phyOut.hwResumeEnable  = st_r.hwResume;

    // ========================================
    // Checks
    a_pulldown_write: assert property (@(posedge clock) disable iff (sys_rst)
        doWrite && hit && st_r.wStrb[2] && st_r.wData[18]
        |=> phyOut.pulldownDisable == 2'h3)
        else $error("pulldowns not disabled after write");

    a_se0_flag_sticky: assert property (@(posedge clock) disable iff (sys_rst)
        st_r.se0Flag && !clrSe0 |=> st_r.se0Flag)
        else $error("se0 resume flag lost without clear");

    a_k_flag_set: assert property (@(posedge clock) disable iff (sys_rst)
        resumeReq && filtLineState == usb_phy_ctrl_pkg::LINE_K
        |-> st_r.kFlag)
        else $error("k resume flag not set on resume");

    a_filter_delay: assert property (@(posedge clock) disable iff (sys_rst)
        $changed(filtLineState) |-> $past(st_r.cnt) == $past(lastCnt)
        && $past(st_r.syncB) == filtLineState)
        else $error("line state passed before stable time");

    a_hw_resume_gate: assert property (@(posedge clock) disable iff (sys_rst)
        resumeReq |-> $past(st_r.hwResume) && $past(suspended)
        && $changed(filtLineState))
        else $error("resume request without hardware resume");

    a_config_pins: assert property (@(posedge clock) disable iff (sys_rst)
        doWrite && hit && st_r.wStrb[0]
        |=> phyOut.phyConfigInputs == $past(st_r.wData[6:4]))
        else $error("phy config pins not following write");

    a_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)
        s_axi_rvalid |-> s_axi_rdata[31:19] == 13'h0
        && s_axi_rdata[17:14] == 4'h0 && s_axi_rdata[3:0] == 4'h0)
        else $error("reserved bits read nonzero");

endmodule
`default_nettype wire

// ==== hw/usb_phy_ctrl_pkg.sv ====
// Package for the USB PHY control register block.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
package usb_phy_ctrl_pkg;

    // ========================================
    // Register map
    localparam logic [7:0] PHY_CONTROL_ADDR = 8'h40;
    localparam logic [31:0] PHY_CONTROL_RST = 32'h00000000;

    // ========================================
    // Field positions
    localparam int PULLDOWN_OFF_BIT = 18;
    localparam int SE0_RESUME_BIT   = 13;
    localparam int K_RESUME_BIT     = 12;
    localparam int FILTER_LSB       = 8;
    localparam int HW_RESUME_BIT    = 7;
    localparam int PHY_CONFIG_LSB   = 4;

    // ========================================
    // Line state codes and bus answers
    localparam logic [1:0] LINE_SE0  = 2'h0;
    localparam logic [1:0] LINE_K    = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLV  = 2'h2;

    typedef struct packed {
        logic [1:0] pulldownDisable;
        logic [2:0] phyConfigInputs;
        logic       hwResumeEnable;
    } phy_out_s;

    typedef struct packed {
        logic        awHeld;
        logic [7:0]  awAddr;
        logic        wHeld;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic        pdOff;
        logic        se0Flag;
        logic        kFlag;
        logic [3:0]  filterLog;
        logic        hwResume;
        logic [2:0]  phyCfg;
        logic [1:0]  syncA;
        logic [1:0]  syncB;
        logic [1:0]  cand;
        logic [15:0] cnt;
        logic [1:0]  filt;
        logic        resumeReq;
    } state_s;

endpackage
